// [design/async_serial_transmitter.sv]
// asynchronous transmit path: holding buffer, shifter, framing and flag
`timescale 1ns/1ps
module async_serial_transmitter #(
  parameter int PIN_COUNT = 4,
  parameter int DIV_WIDTH = serial_tx_pkg::DIVISOR_WIDTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire serial_tx_pkg::tx_config_type config_bits,
  input wire serial_tx_pkg::tx_write_type holding_write,
  input wire logic [DIV_WIDTH-1:0] baud_divisor,
  input wire logic [serial_tx_pkg::PIN_SELECT_WIDTH-1:0] output_pin_select,
  input wire logic tx_irq_mask_enable,
  output logic [PIN_COUNT-1:0] tx_pin_out,
  output logic [PIN_COUNT-1:0] tx_pin_oe,
  output logic tx_buffer_empty_flag,
  output logic tx_irq_request,
  output logic shifter_empty_status
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  serial_tx_pkg::tx_state_type state;
  serial_tx_pkg::tx_state_type next_state;
  logic [serial_tx_pkg::CHAR_WIDTH-1:0] tx_shift_reg;
  logic [serial_tx_pkg::CHAR_WIDTH-1:0] next_tx_shift_reg;
  logic [serial_tx_pkg::BIT_INDEX_WIDTH-1:0] bit_index;
  logic [serial_tx_pkg::BIT_INDEX_WIDTH-1:0] next_bit_index;
  logic [serial_tx_pkg::CHAR_WIDTH-1:0] tx_holding_buffer;
  logic [serial_tx_pkg::CHAR_WIDTH-1:0] next_tx_holding_buffer;
  logic hold_valid;
  logic next_hold_valid;
  logic next_tx_buffer_empty_flag;
  logic next_tx_irq_request;
  logic next_shifter_empty_status;
  logic [PIN_COUNT-1:0] next_tx_pin_out;
  logic [PIN_COUNT-1:0] next_tx_pin_oe;
  logic tx_active;
  logic bit_tick;
  logic frame_level;
  logic line_level;
  logic [3:0] last_index;
  logic take_char;

  //////////////////////////////////////////////////////////////////////////////
  // one-hot driver enable routing; the checks decode the select on their own
  function automatic logic [PIN_COUNT-1:0] pin_decode(
    input logic [serial_tx_pkg::PIN_SELECT_WIDTH-1:0] sel,
    input logic on
  );
    logic [PIN_COUNT-1:0] hot;
    hot = '0;
    for (int k = 0; k < PIN_COUNT; k++) begin
      hot[k] = on && (sel == k[serial_tx_pkg::PIN_SELECT_WIDTH-1:0]);
    end
    return hot;
  endfunction : pin_decode

  //////////////////////////////////////////////////////////////////////////////
  // transmitter enable gating
  always_comb begin
    tx_active = config_bits.serial_port_on && config_bits.transmit_enable &&
                !config_bits.clocked_mode_select;
    last_index = config_bits.nine_bit_tx_select ? serial_tx_pkg::LAST_INDEX_NINE
                                                : serial_tx_pkg::LAST_INDEX_EIGHT;
  end

  //////////////////////////////////////////////////////////////////////////////
  // baud divider; held in reload while idle so a start bit gets a full period
  baud_tick_gen #(
    .WIDTH(DIV_WIDTH)
  ) u_baud (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(state == serial_tx_pkg::IDLE_STATE),
    .wide_divider_select(config_bits.wide_divider_select),
    .divisor(baud_divisor),
    .tick(bit_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // holding buffer and frame sequencer, next values
  always_comb begin
    next_state = state;
    next_tx_shift_reg = tx_shift_reg;
    next_bit_index = bit_index;
    next_tx_holding_buffer = tx_holding_buffer;
    next_hold_valid = hold_valid;
    take_char = 1'b0;
    // ninth bit is sampled with the byte so all nine move as one
    if (holding_write.write_strobe && tx_active) begin
      next_tx_holding_buffer = {holding_write.ninth_tx_bit,
                                holding_write.low_byte};
      next_hold_valid = 1'b1;
    end
    case (state)
      serial_tx_pkg::IDLE_STATE: begin
        // idle shifter takes the waiting character at once
        if (hold_valid) begin
          take_char = 1'b1;
        end
      end
      serial_tx_pkg::START_STATE: begin
        if (bit_tick) begin
          next_state = serial_tx_pkg::DATA_STATE;
        end
      end
      serial_tx_pkg::DATA_STATE: begin
        // step only on ticks; shift right puts the low bit out first
        if (bit_tick) begin
          if (bit_index == last_index) begin
            next_state = serial_tx_pkg::STOP_STATE;
          end else begin
            next_tx_shift_reg = {1'b0, tx_shift_reg[8:1]};
            next_bit_index = bit_index + 1'b1;
          end
        end
      end
      serial_tx_pkg::STOP_STATE: begin
        // single stop bit, then chain the queued character on the boundary
        if (bit_tick) begin
          if (hold_valid) begin
            take_char = 1'b1;
          end else begin
            next_state = serial_tx_pkg::IDLE_STATE;
          end
        end
      end
      default: begin
        next_state = serial_tx_pkg::IDLE_STATE;
      end
    endcase
    if (take_char) begin
      next_state = serial_tx_pkg::START_STATE;
      next_tx_shift_reg = tx_holding_buffer;
      next_bit_index = serial_tx_pkg::INDEX_RESET;
      next_hold_valid = holding_write.write_strobe && tx_active;
    end
    // dropping the enable flushes the shifter and the pending character
    if (!tx_active) begin
      next_state = serial_tx_pkg::IDLE_STATE;
      next_tx_shift_reg = serial_tx_pkg::CHAR_RESET;
      next_bit_index = serial_tx_pkg::INDEX_RESET;
      next_hold_valid = 1'b0;
    end
  end

  // sequencer and buffer registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= serial_tx_pkg::IDLE_STATE;
      tx_shift_reg <= serial_tx_pkg::CHAR_RESET;
      bit_index <= serial_tx_pkg::INDEX_RESET;
      tx_holding_buffer <= serial_tx_pkg::CHAR_RESET;
      hold_valid <= 1'b0;
    end else begin
      state <= next_state;
      tx_shift_reg <= next_tx_shift_reg;
      bit_index <= next_bit_index;
      tx_holding_buffer <= next_tx_holding_buffer;
      hold_valid <= next_hold_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // line level; no parity slot exists, a ninth bit is the only extra
  always_comb begin
    case (state)
      serial_tx_pkg::START_STATE: frame_level = serial_tx_pkg::SPACE_LEVEL;
      serial_tx_pkg::DATA_STATE: frame_level = tx_shift_reg[0];
      serial_tx_pkg::STOP_STATE: frame_level = serial_tx_pkg::MARK_LEVEL;
      default: frame_level = serial_tx_pkg::MARK_LEVEL;
    endcase
    // in clocked mode the invert bit means something else, so it is ignored
    line_level = frame_level ^
                 (config_bits.tx_polarity_invert && !config_bits.clocked_mode_select);
  end

  //////////////////////////////////////////////////////////////////////////////
  // status outputs; flag has no write path at all
  always_comb begin
    // hold_valid lags the write by one edge, so the flag moves on the second
    next_tx_buffer_empty_flag = tx_active &&
        !(hold_valid && state != serial_tx_pkg::IDLE_STATE);
    next_tx_irq_request = tx_buffer_empty_flag && tx_irq_mask_enable;
    next_shifter_empty_status = (next_state == serial_tx_pkg::IDLE_STATE);
    next_tx_pin_oe = pin_decode(output_pin_select, config_bits.serial_port_on);
    next_tx_pin_out = {PIN_COUNT{line_level}};
  end

  // all ports come from these flops; pins and flag trail the sequencer by one cycle, the request by two, shifter_empty_status by none
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_buffer_empty_flag <= serial_tx_pkg::FLAG_RESET;
      tx_irq_request <= serial_tx_pkg::FLAG_RESET;
      shifter_empty_status <= serial_tx_pkg::EMPTY_RESET;
      tx_pin_oe <= '0;
      tx_pin_out <= {PIN_COUNT{serial_tx_pkg::MARK_LEVEL}};
    end else begin
      tx_buffer_empty_flag <= next_tx_buffer_empty_flag;
      tx_irq_request <= next_tx_irq_request;
      shifter_empty_status <= next_shifter_empty_status;
      tx_pin_oe <= next_tx_pin_oe;
      tx_pin_out <= next_tx_pin_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checking helpers: cycles spent in the current bit
  logic [DIV_WIDTH:0] bit_cycles;
  logic [DIV_WIDTH:0] expect_cycles;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cycles <= '0;
    end else if (state == serial_tx_pkg::IDLE_STATE || bit_tick) begin
      bit_cycles <= '0;
    end else begin
      bit_cycles <= bit_cycles + 1'b1;
    end
  end
  always_comb begin
    expect_cycles = {1'b0, baud_divisor};
    if (!config_bits.wide_divider_select) begin
      expect_cycles = {{(DIV_WIDTH - 7){1'b0}}, baud_divisor[7:0]};
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_idle_line_mark: assert property (
    state == serial_tx_pkg::IDLE_STATE && !config_bits.tx_polarity_invert
    |=> tx_pin_out[0] == 1'b1)
    else $error("idle line not at mark");

  a_start_after_load: assert property (
    state == serial_tx_pkg::IDLE_STATE && hold_valid && tx_active
    |=> state == serial_tx_pkg::START_STATE && frame_level == 1'b0)
    else $error("start bit did not follow load");

  a_bit_period_exact: assert property (
    bit_tick && state != serial_tx_pkg::IDLE_STATE |-> bit_cycles == expect_cycles)
    else $error("bit period wrong length");

  a_data_lsb_first: assert property (
    state == serial_tx_pkg::DATA_STATE && bit_tick && bit_index != last_index && tx_active
    |=> frame_level == $past(tx_shift_reg[1]))
    else $error("data not sent low bit first");

  a_disable_flush: assert property (
    !tx_active |=> state == serial_tx_pkg::IDLE_STATE && !hold_valid ##1 shifter_empty_status)
    else $error("disabled transmitter not flushed");

  a_pin_route: assert property (
    config_bits.serial_port_on && $stable(output_pin_select) && $stable(config_bits)
    |=> tx_pin_oe[$past(output_pin_select)] && $onehot(tx_pin_oe))
    else $error("selected pin driver not enabled");

  a_queue_at_stop: assert property (
    state == serial_tx_pkg::STOP_STATE && bit_tick && hold_valid && tx_active
    |=> state == serial_tx_pkg::START_STATE && !hold_valid)
    else $error("queued character not taken at stop");

  a_invert_line: assert property (
    config_bits.tx_polarity_invert && !config_bits.clocked_mode_select &&
    state == serial_tx_pkg::START_STATE |=> tx_pin_out[0] == 1'b1)
    else $error("inverted start bit wrong");

  a_flag_write_lag: assert property (
    holding_write.write_strobe && tx_active && !hold_valid &&
    state == serial_tx_pkg::DATA_STATE && $stable(config_bits)
    |=> tx_buffer_empty_flag ##1 !tx_buffer_empty_flag)
    else $error("flag timing after write wrong");

  a_flag_empty_set: assert property (
    tx_active && !hold_valid |=> tx_buffer_empty_flag)
    else $error("flag missing while buffer empty");

  a_irq_needs_mask: assert property (
    !tx_irq_mask_enable |=> !tx_irq_request)
    else $error("request without mask enable");

  a_nine_bit_count: assert property (
    state == serial_tx_pkg::DATA_STATE |-> bit_index <= last_index)
    else $error("too many data bits");

  a_one_stop: assert property (
    state == serial_tx_pkg::STOP_STATE && bit_tick |=> state != serial_tx_pkg::STOP_STATE)
    else $error("more than one stop bit");

  c_frame_done: cover property (
    state == serial_tx_pkg::STOP_STATE && bit_tick && !hold_valid);
  c_back_to_back: cover property (
    state == serial_tx_pkg::STOP_STATE && bit_tick && hold_valid);
  c_nine_bit: cover property (
    config_bits.nine_bit_tx_select && state == serial_tx_pkg::STOP_STATE);
  c_irq_raised: cover property (tx_irq_request);

endmodule : async_serial_transmitter

// [pkg/serial_tx_pkg.sv]
// shared constants, state codes and carriers for the serial transmitter
package serial_tx_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and levels
  localparam int DIVISOR_WIDTH = 16;
  localparam int NARROW_DIVISOR_WIDTH = 8;
  localparam int CHAR_WIDTH = 9;
  localparam int BIT_INDEX_WIDTH = 4;
  localparam int PIN_SELECT_WIDTH = 2;
  localparam logic MARK_LEVEL = 1'h1;
  localparam logic SPACE_LEVEL = 1'h0;

  //////////////////////////////////////////////////////////////////////////////
  // last data bit index for eight and nine bit characters
  localparam logic [3:0] LAST_INDEX_EIGHT = 4'h7;
  localparam logic [3:0] LAST_INDEX_NINE = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [8:0] CHAR_RESET = 9'h000;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'h0;
  localparam logic EMPTY_RESET = 1'h1;

  //////////////////////////////////////////////////////////////////////////////
  // frame sequencer states
  typedef enum logic [1:0] {
    IDLE_STATE = 2'b00,
    START_STATE = 2'b01,
    DATA_STATE = 2'b10,
    STOP_STATE = 2'b11
  } tx_state_type;

  // control bits that software holds steady between frames
  typedef struct packed {
    logic serial_port_on;
    logic transmit_enable;
    logic clocked_mode_select;
    logic tx_polarity_invert;
    logic nine_bit_tx_select;
    logic wide_divider_select;
  } tx_config_type;

  // one character offered by the processor side
  typedef struct packed {
    logic write_strobe;
    logic ninth_tx_bit;
    logic [7:0] low_byte;
  } tx_write_type;

endpackage : serial_tx_pkg

// [design/baud_tick_gen.sv]
// bit-period tick generator with selectable 8 or 16 bit divider
`timescale 1ns/1ps
module baud_tick_gen #(
  parameter int WIDTH = serial_tx_pkg::DIVISOR_WIDTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic wide_divider_select,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] reload;

  //////////////////////////////////////////////////////////////////////////////
  // narrow mode ignores the upper divisor byte
  always_comb begin
    reload = divisor;
    if (!wide_divider_select) begin
      reload = {{(WIDTH - serial_tx_pkg::NARROW_DIVISOR_WIDTH){1'b0}},
                divisor[serial_tx_pkg::NARROW_DIVISOR_WIDTH-1:0]};
    end
    tick = (count == '0) && !restart;
    next_count = count - 1'b1;
    if (restart || count == '0) begin
      next_count = reload;
    end
  end

  // period is reload plus one clocks, counted from the restart release
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= serial_tx_pkg::DIVISOR_RESET[WIDTH-1:0];
    end else begin
      count <= next_count;
    end
  end

endmodule : baud_tick_gen

// [verif/line_receiver_model.sv]
// behavioural far-end receiver that samples the serial line mid-bit
`timescale 1ns/1ps
module line_receiver_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_line,
  input wire logic invert,
  input wire logic nine_bit,
  input wire logic [15:0] bit_clocks,
  output logic [8:0] rx_data,
  output int rx_count,
  output logic rx_frame_err
);
  logic lvl;
  logic [8:0] shift;

  //////////////////////////////////////////////////////////////////////////////
  // logical level; the receiver is set up with the same polarity as the sender
  assign lvl = serial_line ^ invert;

  // start detect, half-bit check, then one sample per bit period
  initial begin
    rx_data = 9'h000;
    rx_count = 0;
    rx_frame_err = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (!sys_rst && lvl === serial_tx_pkg::SPACE_LEVEL) begin
        repeat (bit_clocks / 2) @(posedge clk_sys);
        // a glitch shorter than half a bit is dropped, as a real receiver would
        if (lvl === serial_tx_pkg::SPACE_LEVEL) begin
          shift = 9'h000;
          for (int i = 0; i < (nine_bit ? 9 : 8); i++) begin
            repeat (bit_clocks) @(posedge clk_sys);
            shift[i] = lvl;
          end
          repeat (bit_clocks) @(posedge clk_sys);
          rx_frame_err = (lvl !== serial_tx_pkg::MARK_LEVEL);
          rx_data = shift;
          rx_count++;
        end
      end
    end
  end
endmodule : line_receiver_model

// [verif/testbench.sv]
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [1:0] sel; logic wide; logic nine; logic inv; logic [15:0] div;
    int bclk; logic ninth; logic [7:0] data; int lowbits;} row_type;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  serial_tx_pkg::tx_config_type cfg = '0;
  serial_tx_pkg::tx_write_type wr = '0;
  logic [15:0] div = 16'h0103;
  logic [1:0] sel = 2'h0;
  logic mask = 1'b0;
  logic [15:0] bclk = 16'h0004;
  logic [3:0] pin_out;
  logic [3:0] oe;
  logic flag;
  logic irq;
  logic shifter_empty;
  logic serial_line;
  logic lvl;
  logic line_inv = 1'b0;
  logic [8:0] rx_data;
  logic rx_frame_err;
  logic [8:0] exp;
  int rx_count;
  int err_total = 0;
  int n_checks = 0;
  int cnt;
  int n;
  int w;
  // narrow rows use only the low byte of 16'h0103, so a bit lasts four clocks
  row_type rows [5] = '{
    '{2'h0, 1'b0, 1'b0, 1'b0, 16'h0103, 4, 1'b1, 8'h00, 9},
    '{2'h1, 1'b1, 1'b0, 1'b0, 16'h0005, 6, 1'b0, 8'h01, 1},
    '{2'h2, 1'b0, 1'b1, 1'b0, 16'h0103, 4, 1'b0, 8'h00, 10},
    '{2'h3, 1'b1, 1'b1, 1'b1, 16'h0005, 6, 1'b1, 8'h80, 8},
    '{2'h0, 1'b1, 1'b0, 1'b0, 16'h0000, 1, 1'b0, 8'h5a, 2}};

  //////////////////////////////////////////////////////////////////////////////
  // clock, line decode and the two instances
  always #12.5 clk_sys = ~clk_sys;
  assign serial_line = pin_out[sel];
  // the pin is registered, so the far end follows a new polarity one edge later
  always @(posedge clk_sys) line_inv <= cfg.tx_polarity_invert;
  assign lvl = serial_line ^ line_inv;

  async_serial_transmitter #(.PIN_COUNT(4), .DIV_WIDTH(16)) i_async_serial_transmitter (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .config_bits(cfg), .holding_write(wr),
    .baud_divisor(div), .output_pin_select(sel), .tx_irq_mask_enable(mask),
    .tx_pin_out(pin_out), .tx_pin_oe(oe), .tx_buffer_empty_flag(flag),
    .tx_irq_request(irq), .shifter_empty_status(shifter_empty));

  line_receiver_model i_line_receiver_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_line(serial_line),
    .invert(line_inv), .nine_bit(cfg.nine_bit_tx_select), .bit_clocks(bclk),
    .rx_data(rx_data), .rx_count(rx_count), .rx_frame_err(rx_frame_err));

  //////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // one-cycle strobe; returns in the time step of the edge that drops it
  task automatic send(input logic ninth, input logic [7:0] data);
    @(posedge clk_sys);
    wr <= '{1'b1, ninth, data};
    @(posedge clk_sys);
    wr <= '0;
  endtask : send

  // w edges until the level shows, then n edges it lasts; calls chain without loss
  task automatic run_len(input logic lv, output int rn, output int rw);
    rw = 0;
    rn = 0;
    while (lvl !== lv && rw < 5000) begin
      rw++;
      @(posedge clk_sys);
    end
    while (lvl === lv && rn < 5000) begin
      rn++;
      @(posedge clk_sys);
    end
  endtask : run_len

  task automatic wait_rx(input int target);
    int k;
    k = 0;
    while (rx_count < target && k < 5000) begin
      k++;
      @(posedge clk_sys);
    end
    check(rx_count >= target, "receiver saw no frame");
  endtask : wait_rx

  //////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    check(pin_out === 4'hf && oe === 4'h0 && shifter_empty === 1'b1, "reset outputs");
    check(flag === 1'b0 && irq === 1'b0, "reset flag");
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      cfg <= '{1'b1, 1'b1, 1'b0, rows[i].inv, rows[i].nine, rows[i].wide};
      sel <= rows[i].sel;
      div <= rows[i].div;
      bclk <= 16'(rows[i].bclk);
      repeat (4) @(posedge clk_sys);
      check(oe === 4'h1 << rows[i].sel, "driver enable");
      check(lvl === 1'b1 && flag === 1'b1, "idle line or flag");
      check(irq === 1'b0, "request without mask");
      exp = rows[i].nine ? {rows[i].ninth, rows[i].data} : {1'b0, rows[i].data};
      cnt = rx_count;
      send(rows[i].ninth, rows[i].data);
      run_len(1'b0, n, w);
      check(w == 3, "start bit latency");
      check(n == rows[i].lowbits * rows[i].bclk, "low run length");
      check(shifter_empty === 1'b0, "shifter busy");
      wait_rx(cnt + 1);
      check(rx_data === exp && rx_frame_err === 1'b0, "received char");
      repeat (2 * rows[i].bclk + 3) @(posedge clk_sys);
      check(shifter_empty === 1'b1 && lvl === 1'b1, "back to idle");
    end
    // back to back: second write lands while the first frame is on the line
    @(posedge clk_sys);
    cfg <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    sel <= 2'h1;
    div <= 16'h0103;
    bclk <= 16'h0004;
    mask <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(irq === 1'b1, "request with mask");
    cnt = rx_count;
    send(1'b0, 8'hff);
    run_len(1'b0, n, w);
    fork
      run_len(1'b1, n, w);
      begin
        send(1'b0, 8'h00);
        @(posedge clk_sys);
        check(flag === 1'b1, "flag changed too early");
        @(posedge clk_sys);
        check(flag === 1'b0, "flag with char queued");
        @(posedge clk_sys);
        check(irq === 1'b0, "request while full");
        mask <= 1'b0;
      end
    join
    check(n == 36, "gap between frames");
    wait_rx(cnt + 2);
    check(rx_data === 9'h000 && flag === 1'b1, "queued char");
    // clocked mode keeps the asynchronous path shut
    repeat (10) @(posedge clk_sys);
    cfg.clocked_mode_select <= 1'b1;
    cnt = rx_count;
    send(1'b0, 8'h00);
    repeat (20) @(posedge clk_sys);
    check(rx_count == cnt && flag === 1'b0 && shifter_empty === 1'b1, "clocked mode");
    cfg.clocked_mode_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // abort in mid-frame, then a clean frame
    send(1'b0, 8'h00);
    repeat (10) @(posedge clk_sys);
    cfg.transmit_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(lvl === 1'b1 && shifter_empty === 1'b1 && flag === 1'b0, "abort");
    cfg.transmit_enable <= 1'b1;
    repeat (60) @(posedge clk_sys);
    cnt = rx_count;
    send(1'b1, 8'h35);
    wait_rx(cnt + 1);
    check(rx_data === 9'h035, "frame after re-enable");
    final_report();
  end
endmodule : testbench
